// ---- design/bdsp_map.svh ----
// constants of the burst-four double-data-rate sram port
`ifndef BDSP_MAP_SVH
`define BDSP_MAP_SVH
`define BDSP_ADDR_W      17
`define BDSP_DATA_W      36
`define BDSP_LANES       4
`define BDSP_LANE_W      9
`define BDSP_NIBBLES     2
`define BDSP_NIBBLE_W    4
`define BDSP_BURST_LEN   4
`define BDSP_BEAT_W      2
`define BDSP_LAST_BEAT   2'h3
`define BDSP_RD_TAP      2
`define BDSP_PIPE_W      6
`define BDSP_SEL_RESET   1'h1
`endif

// ---- design/bdsp_pkg.sv ----
// types shared by both ends of the sram port
`include "bdsp_map.svh"
package bdsp_pkg;
   typedef logic [`BDSP_ADDR_W-1:0]                  bdsp_addr_t;
   typedef logic [`BDSP_DATA_W-1:0]                  bdsp_word_t;
   typedef logic [`BDSP_LANES-1:0]                   bdsp_bmask_t;
   typedef logic [`BDSP_NIBBLES-1:0]                 bdsp_nmask_t;
   typedef logic [`BDSP_BEAT_W-1:0]                  bdsp_beat_t;
   typedef logic [`BDSP_BURST_LEN*`BDSP_DATA_W-1:0]  bdsp_burst_t;
   typedef logic [`BDSP_BURST_LEN*`BDSP_LANES-1:0]   bdsp_bmask_burst_t;
endpackage : bdsp_pkg

// ---- design/bdsp_if.sv ----
// pin bundle between memory controller and sram port
`timescale 1ns/1ns
interface bdsp_if;
   logic                  k;
   logic                  k_n;
   logic                  c;
   logic                  c_n;
   logic                  write_port_select_n;
   logic                  read_port_select_n;
   bdsp_pkg::bdsp_addr_t  address;
   bdsp_pkg::bdsp_word_t  write_data;
   bdsp_pkg::bdsp_bmask_t byte_write_mask_n;
   bdsp_pkg::bdsp_nmask_t nibble_write_mask_n;
   bdsp_pkg::bdsp_word_t  read_data;
   logic                  read_data_oe;

   modport device
   (
      input  k, k_n, c, c_n, write_port_select_n, read_port_select_n, address,
      input  write_data, byte_write_mask_n, nibble_write_mask_n,
      output read_data, read_data_oe
   );

   modport ctrl
   (
      output k, k_n, c, c_n, write_port_select_n, read_port_select_n, address,
      output write_data, byte_write_mask_n, nibble_write_mask_n,
      input  read_data, read_data_oe
   );
endinterface : bdsp_if

// ---- design/bdsp_device.sv ----
// sram end: write/read port logic and four-sub-array storage
//
// Notes on behaviour
// - write select low at k rise starts write when no write burst is running
// - write select high: no new write starts; a running burst still takes data
// - nibble masks gate bits 3:0 and 7:4
// - masked nibble is discarded, not stored
// - byte masks gate four nine-bit lanes
// - masked lane keeps stored value unchanged
// - masks sampled on same edge as data
// - one address bus, sampled at k rise
// - four sub-arrays, one per burst word
// - address ignored when port deselected
// - read select low at k rise starts read
// - read deselect still finishes running burst
// - outputs float after next c rise, or next k rise in single clock mode
// - each read returns four words in sequence
// - read data launched by output clock pair
// - inputs on both edges, access on k rise
// - single clock mode launches from k pair
// - write data taken one word per edge
`timescale 1ns/1ns
`include "bdsp_map.svh"
module bdsp_device
(
   input  wire logic ref_clk,
   input  wire logic resetn,
   input  wire logic nibble_mode,
   input  wire logic single_clock_mode,
   bdsp_if.device    pins
);

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   // the beat number picks the sub-array, the address the row in it
   localparam int DEPTH = 2 ** (`BDSP_ADDR_W + `BDSP_BEAT_W);

   bdsp_pkg::bdsp_word_t mem [DEPTH];

   // ----------------------------------------------------------------
   // clock edge detection
   // ----------------------------------------------------------------
   // each ref_clk cycle is one data beat; the link clocks toggle per beat
   logic                 k_q_reg;
   logic                 c_q_reg;
   logic                 k_rise;
   logic                 k_edge;
   logic                 c_edge;
   logic                 c_rise;
   logic                 launch;
   logic                 out_rise;

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         k_q_reg <= 1'h0;
         c_q_reg <= 1'h0;
      end
      else
      begin
         k_q_reg <= pins.k;
         c_q_reg <= pins.c;
      end
   end

   // k rise and k_n rise both mark a capture beat
   assign k_rise   = pins.k & ~k_q_reg;
   assign k_edge   = pins.k ^ k_q_reg;
   assign c_edge   = pins.c ^ c_q_reg;
   assign c_rise   = pins.c & ~c_q_reg;
   // single clock mode swaps the output clock pair for the input pair
   assign launch   = single_clock_mode ? k_edge : c_edge;
   assign out_rise = single_clock_mode ? k_rise : c_rise;

   // ----------------------------------------------------------------
   // write port
   // ----------------------------------------------------------------
   logic                 wr_go;
   logic                 wr_busy;
   logic                 wr_beat_act;
   bdsp_pkg::bdsp_beat_t wr_beat_reg;
   bdsp_pkg::bdsp_addr_t wr_addr_reg;
   bdsp_pkg::bdsp_addr_t wr_row;
   bdsp_pkg::bdsp_beat_t wr_beat;
   bdsp_pkg::bdsp_word_t bit_en;

   // a new write is only taken once the previous burst has drained
   assign wr_busy     = (wr_beat_reg != '0);
   assign wr_go       = k_rise & ~pins.write_port_select_n & ~wr_busy;
   assign wr_beat_act = wr_go | wr_busy;
   assign wr_row      = wr_go ? pins.address : wr_addr_reg;
   assign wr_beat     = wr_go ? '0 : wr_beat_reg;

   // beat counter and latched address of the running write burst
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wr_beat_reg <= '0;
         wr_addr_reg <= '0;
      end
      else
      begin
         if (wr_go)
         begin
            wr_addr_reg <= pins.address;
         end
         if (wr_beat_act)
         begin
            // wraps to zero after the fourth word
            wr_beat_reg <= wr_beat + 2'h1;
         end
      end
   end

   // per-lane bit enables from the masks of the current beat
   genvar gl;
   generate
      for (gl = 0; gl < `BDSP_LANES; gl++)
      begin : g_lane
         logic lane_on;
         always_comb
         begin
            if (nibble_mode)
            begin
               // narrow variant: only two nibbles exist, upper lanes unused
               lane_on = 1'h0;
            end
            else
            begin
               lane_on = ~pins.byte_write_mask_n[gl];
            end
         end
         assign bit_en[gl*`BDSP_LANE_W +: `BDSP_LANE_W] = {`BDSP_LANE_W{lane_on}};
      end
   endgenerate

   // nibble enables override the lane enables in narrow mode
   logic [`BDSP_NIBBLES*`BDSP_NIBBLE_W-1:0] nib_en;
   genvar gn;
   generate
      for (gn = 0; gn < `BDSP_NIBBLES; gn++)
      begin : g_nib
         assign nib_en[gn*`BDSP_NIBBLE_W +: `BDSP_NIBBLE_W] =
            {`BDSP_NIBBLE_W{~pins.nibble_write_mask_n[gn]}};
      end
   endgenerate

   bdsp_pkg::bdsp_word_t wr_keep;

   always_comb
   begin
      wr_keep = bit_en;
      if (nibble_mode)
      begin
         wr_keep = '0;
         wr_keep[`BDSP_NIBBLES*`BDSP_NIBBLE_W-1:0] = nib_en;
      end
   end

   // array update: masked bits keep their old value, masks and data same beat
   always_ff @(posedge ref_clk)
   begin
      if (wr_beat_act)
      begin
         mem[{wr_row, wr_beat}] <= (mem[{wr_row, wr_beat}] & ~wr_keep) |
                                   (pins.write_data & wr_keep);
      end
   end

   // ----------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------
   logic                 rd_go;
   logic                 rd_pend_reg;
   bdsp_pkg::bdsp_addr_t rd_pend_addr_reg;
   logic                 rd_busy_reg;
   bdsp_pkg::bdsp_beat_t rd_beat_reg;
   bdsp_pkg::bdsp_addr_t rd_addr_reg;
   bdsp_pkg::bdsp_addr_t rd_row;
   bdsp_pkg::bdsp_beat_t rd_beat;
   logic                 rd_take;
   bdsp_pkg::bdsp_word_t q_reg;
   logic                 q_oe_reg;

   assign rd_go   = k_rise & ~pins.read_port_select_n;
   assign rd_take = launch & (rd_busy_reg | rd_pend_reg);
   assign rd_row  = rd_busy_reg ? rd_addr_reg : rd_pend_addr_reg;
   assign rd_beat = rd_busy_reg ? rd_beat_reg : '0;

   // one request may wait while a burst runs; a new start sets over a take
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rd_pend_reg      <= 1'h0;
         rd_pend_addr_reg <= '0;
      end
      else if (rd_go)
      begin
         rd_pend_reg      <= 1'h1;
         rd_pend_addr_reg <= pins.address;
      end
      else if (rd_take && !rd_busy_reg)
      begin
         rd_pend_reg      <= 1'h0;
      end
   end

   // burst sequencer: four words, one per c edge, or one per k edge in single clock mode
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rd_busy_reg <= 1'h0;
         rd_beat_reg <= '0;
         rd_addr_reg <= '0;
      end
      else if (rd_take)
      begin
         if (!rd_busy_reg)
         begin
            rd_addr_reg <= rd_pend_addr_reg;
         end
         rd_beat_reg <= rd_beat + 2'h1;
         // deselect does not cut a running burst short
         rd_busy_reg <= (rd_beat != `BDSP_LAST_BEAT);
      end
   end

   // output drivers: data straight from flops, float after next output rise
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         q_reg    <= '0;
         q_oe_reg <= 1'h0;
      end
      else if (rd_take)
      begin
         q_reg    <= mem[{rd_row, rd_beat}];
         q_oe_reg <= 1'h1;
      end
      else if (out_rise && q_oe_reg)
      begin
         q_oe_reg <= 1'h0;
      end
   end

   assign pins.read_data    = q_reg;
   assign pins.read_data_oe = q_oe_reg;

endmodule : bdsp_device

// ---- design/bdsp_ctrl.sv ----
// controller end: clock pairs, command issue, write beats, read capture
`timescale 1ns/1ns
`include "bdsp_map.svh"
module bdsp_ctrl
(
   input  wire logic                       ref_clk,
   input  wire logic                       resetn,
   input  wire logic                       wr_req,
   input  wire bdsp_pkg::bdsp_addr_t       wr_addr,
   input  wire bdsp_pkg::bdsp_burst_t      wr_data,
   input  wire bdsp_pkg::bdsp_bmask_burst_t wr_mask_n,
   input  wire bdsp_pkg::bdsp_nmask_t      wr_nib_mask_n,
   input  wire logic                       rd_req,
   input  wire bdsp_pkg::bdsp_addr_t       rd_addr,
   output      logic                       wr_taken,
   output      logic                       rd_taken,
   output      bdsp_pkg::bdsp_burst_t      rd_data,
   output      logic                       rd_valid,
   bdsp_if.ctrl                            pins
);

   // ----------------------------------------------------------------
   // clock pairs
   // ----------------------------------------------------------------
   // both pairs toggle every cycle; c matches k so board skew is zero here
   logic k_reg;
   logic k_n_reg;
   logic c_reg;
   logic c_n_reg;

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         k_reg   <= 1'h0;
         k_n_reg <= 1'h1;
         c_reg   <= 1'h0;
         c_n_reg <= 1'h1;
      end
      else
      begin
         k_reg   <= ~k_reg;
         k_n_reg <= k_reg;
         c_reg   <= ~c_reg;
         c_n_reg <= c_reg;
      end
   end

   // ----------------------------------------------------------------
   // command issue
   // ----------------------------------------------------------------
   logic                  slot;
   logic                  rd_go;
   logic                  wr_go;
   bdsp_pkg::bdsp_beat_t  wr_beat_reg;
   bdsp_pkg::bdsp_beat_t  rd_gap_reg;
   bdsp_pkg::bdsp_burst_t wr_buf_reg;
   bdsp_pkg::bdsp_bmask_burst_t wr_mbuf_reg;
   bdsp_pkg::bdsp_nmask_t wr_nbuf_reg;

   // commands change with k rising; the address bus serves one port per rise
   assign slot  = ~k_reg;
   assign rd_go = slot & rd_req & (rd_gap_reg == '0);
   assign wr_go = slot & wr_req & ~rd_req & (wr_beat_reg == '0);

   logic                  wps_n_reg;
   logic                  rps_n_reg;
   bdsp_pkg::bdsp_addr_t  addr_reg;
   bdsp_pkg::bdsp_word_t  wdata_reg;
   bdsp_pkg::bdsp_bmask_t bmask_reg;
   bdsp_pkg::bdsp_nmask_t nmask_reg;
   logic                  wr_taken_reg;
   logic                  rd_taken_reg;

   // selects, address and acknowledge pulses
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wps_n_reg    <= `BDSP_SEL_RESET;
         rps_n_reg    <= `BDSP_SEL_RESET;
         addr_reg     <= '0;
         wr_taken_reg <= 1'h0;
         rd_taken_reg <= 1'h0;
      end
      else
      begin
         wps_n_reg    <= ~wr_go;
         rps_n_reg    <= ~rd_go;
         wr_taken_reg <= wr_go;
         rd_taken_reg <= rd_go;
         if (rd_go)
         begin
            addr_reg <= rd_addr;
         end
         else if (wr_go)
         begin
            addr_reg <= wr_addr;
         end
      end
   end

   // read spacing counter: four beats per burst
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rd_gap_reg <= '0;
      end
      else if (rd_go || rd_gap_reg != '0)
      begin
         rd_gap_reg <= rd_gap_reg + 2'h1;
      end
   end

   // write beats: word and masks presented together, one per edge
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wr_beat_reg <= '0;
         wr_buf_reg  <= '0;
         wr_mbuf_reg <= '1;
         wr_nbuf_reg <= '1;
         wdata_reg   <= '0;
         bmask_reg   <= '1;
         nmask_reg   <= '1;
      end
      else if (wr_go)
      begin
         wr_beat_reg <= 2'h1;
         wr_buf_reg  <= wr_data;
         wr_mbuf_reg <= wr_mask_n;
         wr_nbuf_reg <= wr_nib_mask_n;
         wdata_reg   <= wr_data[0 +: `BDSP_DATA_W];
         bmask_reg   <= wr_mask_n[0 +: `BDSP_LANES];
         nmask_reg   <= wr_nib_mask_n;
      end
      else if (wr_beat_reg != '0)
      begin
         wr_beat_reg <= wr_beat_reg + 2'h1;
         wdata_reg   <= wr_buf_reg[wr_beat_reg*`BDSP_DATA_W +: `BDSP_DATA_W];
         bmask_reg   <= wr_mbuf_reg[wr_beat_reg*`BDSP_LANES +: `BDSP_LANES];
         nmask_reg   <= wr_nbuf_reg;
      end
      else
      begin
         // idle beats carry masked data
         wdata_reg   <= '0;
         bmask_reg   <= '1;
         nmask_reg   <= '1;
      end
   end

   // ----------------------------------------------------------------
   // read capture
   // ----------------------------------------------------------------
   // fixed latency from issue; pipe bit n marks n+1 edges after issue
   logic [`BDSP_PIPE_W-1:0] rd_pipe_reg;
   bdsp_pkg::bdsp_burst_t   rd_data_reg;
   logic                    rd_valid_reg;

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rd_pipe_reg  <= '0;
         rd_data_reg  <= '0;
         rd_valid_reg <= 1'h0;
      end
      else
      begin
         rd_pipe_reg  <= {rd_pipe_reg[`BDSP_PIPE_W-2:0], rd_go};
         rd_valid_reg <= rd_pipe_reg[`BDSP_PIPE_W-1];
         for (int i = 0; i < `BDSP_BURST_LEN; i++)
         begin
            if (rd_pipe_reg[`BDSP_RD_TAP + i])
            begin
               rd_data_reg[i*`BDSP_DATA_W +: `BDSP_DATA_W] <= pins.read_data;
            end
         end
      end
   end

   assign pins.k                   = k_reg;
   assign pins.k_n                 = k_n_reg;
   assign pins.c                   = c_reg;
   assign pins.c_n                 = c_n_reg;
   assign pins.write_port_select_n = wps_n_reg;
   assign pins.read_port_select_n  = rps_n_reg;
   assign pins.address             = addr_reg;
   assign pins.write_data          = wdata_reg;
   assign pins.byte_write_mask_n   = bmask_reg;
   assign pins.nibble_write_mask_n = nmask_reg;
   assign wr_taken                 = wr_taken_reg;
   assign rd_taken                 = rd_taken_reg;
   assign rd_data                  = rd_data_reg;
   assign rd_valid                 = rd_valid_reg;

endmodule : bdsp_ctrl

// ---- testbench/bdsp_link_props.sv ----
// link-level assertions between the controller end and the sram end
`timescale 1ns/1ns
module bdsp_link_props
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic k,
   input wire logic k_n,
   input wire logic c,
   input wire logic c_n,
   input wire logic write_port_select_n,
   input wire logic read_port_select_n,
   input wire logic read_data_oe
);
   logic k_prev_reg;
   logic rd_start;
   logic wr_start;

   // ----------------------------------------
   // helper logic
   // ----------------------------------------
   // k history, so a k rise is seen at the same edge the device samples
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         k_prev_reg <= 1'h0;
      end
      else
      begin
         k_prev_reg <= k;
      end
   end

   // access starts exist only on a k rise
   assign rd_start = k && !k_prev_reg && !read_port_select_n;
   assign wr_start = k && !k_prev_reg && !write_port_select_n;

   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);

   sequence s_rd_start;
      rd_start;
   endsequence
   sequence s_rd_beats;
      read_data_oe [*4];
   endsequence
   sequence s_rd_quiet;
      s_rd_start ##1 !rd_start [*6];
   endsequence

   property p_kn_compl;
      k_n == !k;
   endproperty
   property p_c_pair;
      (c == k) && (c_n == !c);
   endproperty
   property p_rd_burst;
      s_rd_start |-> ##2 s_rd_beats;
   endproperty
   property p_oe_drop;
      s_rd_quiet |=> !read_data_oe;
   endproperty
   property p_oe_rise;
      $rose(read_data_oe) |-> $past(rd_start, 2);
   endproperty
   property p_wr_space;
      wr_start |=> !wr_start [*3];
   endproperty
   property p_rd_space;
      rd_start |=> !rd_start [*3];
   endproperty
   property p_one_addr;
      !(rd_start && wr_start);
   endproperty

   a_kn_compl: assert property (p_kn_compl) else $error("k pair not complementary");
   a_c_pair: assert property (p_c_pair) else $error("output clock pair off");
   a_rd_burst: assert property (p_rd_burst) else $error("read burst short");
   a_oe_drop: assert property (p_oe_drop) else $error("read drivers not released");
   a_oe_rise: assert property (p_oe_rise) else $error("drivers on without read");
   a_wr_space: assert property (p_wr_space) else $error("write starts too close");
   a_rd_space: assert property (p_rd_space) else $error("read starts too close");
   a_one_addr: assert property (p_one_addr) else $error("read and write share k rise");
endmodule : bdsp_link_props

// ---- testbench/tb_top.sv ----
// self-checking bench: controller and sram ends joined by the pin bundle
`timescale 1ns/1ns
module tb_top;
   typedef struct {bdsp_pkg::bdsp_addr_t a; bdsp_pkg::bdsp_bmask_burst_t m;
      bdsp_pkg::bdsp_nmask_t n; logic nm;} bdsp_row_t;

   logic                        ref_clk;
   logic                        resetn;
   logic                        nibble_mode;
   logic                        single_clock_mode;
   logic                        wr_req;
   logic                        rd_req;
   bdsp_pkg::bdsp_addr_t        wr_addr;
   bdsp_pkg::bdsp_addr_t        rd_addr;
   bdsp_pkg::bdsp_burst_t       wr_data;
   bdsp_pkg::bdsp_bmask_burst_t wr_mask_n;
   bdsp_pkg::bdsp_nmask_t       wr_nib_mask_n;
   logic                        wr_taken;
   logic                        rd_taken;
   logic                        rd_valid;
   bdsp_pkg::bdsp_burst_t       rd_data;
   bdsp_pkg::bdsp_word_t        mem [int];
   int                          num_errors;
   int                          n_tests;
   bdsp_row_t                   rows [6];

   bdsp_if i_bdsp_if();

   bdsp_ctrl i_bdsp_ctrl (.ref_clk(ref_clk), .resetn(resetn), .wr_req(wr_req),
      .wr_addr(wr_addr), .wr_data(wr_data), .wr_mask_n(wr_mask_n),
      .wr_nib_mask_n(wr_nib_mask_n), .rd_req(rd_req), .rd_addr(rd_addr),
      .wr_taken(wr_taken), .rd_taken(rd_taken), .rd_data(rd_data),
      .rd_valid(rd_valid), .pins(i_bdsp_if));

   bdsp_device i_bdsp_device (.ref_clk(ref_clk), .resetn(resetn), .nibble_mode(nibble_mode),
      .single_clock_mode(single_clock_mode), .pins(i_bdsp_if));

   bdsp_link_props i_bdsp_link_props (.ref_clk(ref_clk), .resetn(resetn),
      .k(i_bdsp_if.k), .k_n(i_bdsp_if.k_n), .c(i_bdsp_if.c), .c_n(i_bdsp_if.c_n),
      .write_port_select_n(i_bdsp_if.write_port_select_n),
      .read_port_select_n(i_bdsp_if.read_port_select_n),
      .read_data_oe(i_bdsp_if.read_data_oe));

   // ----------------------------------------
   // clock, compare and closing
   // ----------------------------------------
   initial
   begin
      ref_clk = 1'h0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic chk(input string nm, input logic [143:0] seen, input logic [143:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop

   // whole run is under two hundred cycles; this only cuts a hang short
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      num_errors++;
      $display("[ERR] watchdog expected done seen hang");
      report_and_stop();
   end

   // ----------------------------------------
   // transfers and the reference array
   // ----------------------------------------
   function automatic bdsp_pkg::bdsp_burst_t pat(input int i);
      bdsp_pkg::bdsp_burst_t p;
      for (int j = 0; j < 4; j++)
         p[36*j+:36] = 36'h9A5C3E71B ^ (36'(i) * 36'h111111111) ^ (36'(j) << 28);
      return p;
   endfunction : pat

   // model update follows the masks; masked lanes keep their old value
   task automatic do_write(input bdsp_pkg::bdsp_addr_t a, input bdsp_pkg::bdsp_burst_t d,
      input bdsp_pkg::bdsp_bmask_burst_t m, input bdsp_pkg::bdsp_nmask_t n);
      bdsp_pkg::bdsp_word_t w;
      int                   t;
      for (int j = 0; j < 4; j++)
      begin
         w = mem.exists(int'({a, 2'(j)})) ? mem[int'({a, 2'(j)})] : 'x;
         for (int b = 0; b < 4; b++)
            if (nibble_mode && b < 2 && !n[b])
               w[4*b+:4] = d[36*j+4*b+:4];
            else if (!nibble_mode && !m[4*j+b])
               w[9*b+:9] = d[36*j+9*b+:9];
         mem[int'({a, 2'(j)})] = w;
      end
      @(negedge ref_clk);
      {wr_addr, wr_data, wr_mask_n, wr_nib_mask_n, wr_req} = {a, d, m, n, 1'h1};
      for (t = 0; t < 50 && wr_taken !== 1'h1; t++)
         @(negedge ref_clk);
      wr_req = 1'h0;
      chk("wr_taken", wr_taken, 1'h1);
   endtask : do_write

   task automatic check_read(input bdsp_pkg::bdsp_addr_t a);
      bdsp_pkg::bdsp_burst_t e;
      int                    t;
      @(negedge ref_clk);
      {rd_addr, rd_req} = {a, 1'h1};
      for (t = 0; t < 50 && rd_taken !== 1'h1; t++)
         @(negedge ref_clk);
      rd_req = 1'h0;
      chk("rd_taken", rd_taken, 1'h1);
      for (t = 0; t < 50 && rd_valid !== 1'h1; t++)
         @(negedge ref_clk);
      chk("rd_valid", rd_valid, 1'h1);
      for (int j = 0; j < 4; j++)
         e[36*j+:36] = mem.exists(int'({a, 2'(j)})) ? mem[int'({a, 2'(j)})] : 'x;
      chk("rd_data", rd_data, e);
   endtask : check_read

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      num_errors = 0;
      n_tests = 0;
      {resetn, nibble_mode, single_clock_mode, wr_req, rd_req} = 5'h00;
      {wr_addr, rd_addr, wr_data, wr_nib_mask_n} = '0;
      wr_mask_n = 16'hFFFF;
      rows[0] = '{17'h00000, 16'h0000, 2'h3, 1'h0};
      rows[1] = '{17'h1FFFF, 16'h0000, 2'h3, 1'h0};
      rows[2] = '{17'h00000, 16'h5A3C, 2'h3, 1'h0};
      rows[3] = '{17'h00000, 16'h0000, 2'h2, 1'h1};
      rows[4] = '{17'h1FFFF, 16'h0000, 2'h1, 1'h1};
      rows[5] = '{17'h1FFFF, 16'hFFFF, 2'h0, 1'h0};
      repeat (15) @(negedge ref_clk);
      chk("reset_pins", {i_bdsp_if.k, i_bdsp_if.k_n, i_bdsp_if.c, i_bdsp_if.c_n,
         i_bdsp_if.write_port_select_n, i_bdsp_if.read_port_select_n,
         i_bdsp_if.read_data_oe, wr_taken, rd_taken, rd_valid}, 10'h170);
      @(negedge ref_clk);
      resetn = 1'h1;
      // rows: full writes first so later masked writes have a known base
      for (int i = 0; i < 6; i++)
      begin
         nibble_mode = rows[i].nm;
         do_write(rows[i].a, pat(i), rows[i].m, rows[i].n);
         check_read(rows[i].a);
      end
      nibble_mode = 1'h0;
      // a write and a read held together, to different addresses
      do_write(17'h00002, pat(7), 16'h0000, 2'h3);
      fork
         do_write(17'h00002, pat(8), 16'h0F00, 2'h3);
         check_read(17'h1FFFF);
      join
      check_read(17'h00002);
      check_read(17'h00000);
      single_clock_mode = 1'h1;
      check_read(17'h1FFFF);
      single_clock_mode = 1'h0;
      repeat (10) @(negedge ref_clk);
      chk("idle_pins", {i_bdsp_if.read_data_oe, i_bdsp_if.write_port_select_n,
         i_bdsp_if.read_port_select_n}, 3'h3);
      // reset mid-run: pins idle again, array contents survive
      resetn = 1'h0;
      repeat (2) @(negedge ref_clk);
      chk("reset_again", {i_bdsp_if.k, i_bdsp_if.write_port_select_n,
         i_bdsp_if.read_port_select_n, i_bdsp_if.read_data_oe}, 4'h6);
      resetn = 1'h1;
      check_read(17'h00000);
      report_and_stop();
   end
endmodule : tb_top
